// file: sync_monitor_phase_ramp.sv
// Sync monitor configuration, phase offset glide and calibration.
// Assumes phase_target comes from the offset registers on clk_sys,
// and the divider reset and holdover outputs reach the DPLL core.
`timescale 1ns/100ps
`include "sync_glide_cfg.svh"

module sync_monitor_phase_ramp #(
  parameter logic [`WATCH_CNT_W-1:0] WINDOW_BASE = 16'h0001
) (
  input wire logic clk_sys, // System clock, 50 MHz
  input wire logic arst_n, // Async reset, low
  input sync_glide_pkg::reg_req_type bus, // Register request
  output logic [7:0] rd_data, // Read data, next cycle
  input wire logic [`PHASE_W-1:0] phase_target, // Programmed offset
  input wire logic sync_in, // Frame-sync pin
  input wire logic in_clk, // Input clock pin
  output logic [`PHASE_W-1:0] phase_offset, // Applied offset
  output logic holdover_req, // Holdover request
  output logic divider_reset, // Divider reset pulse
  output logic sync_alarm, // Sync alarm level
  output logic [2:0] irq_pin_cfg // Interrupt pin setup
);

  localparam logic [`GLIDE_DIV_W-1:0] STEP_LAST =
    `GLIDE_DIV_W'(`GLIDE_STEP_CYC - 1);

  localparam sync_glide_pkg::glide_state_type RESET_STATE = '{
    watch_cfg: `SYNC_WATCH_RESET & `SYNC_WATCH_MASK,
    irq_cfg: 3'(`IRQ_PIN_RESET & `IRQ_PIN_MASK),
    rdata: 8'h00,
    cal: sync_glide_pkg::CAL_IDLE,
    offset: '0,
    div: '0,
    holdover: 1'b0,
    div_reset: 1'b0
  };

  sync_glide_pkg::glide_state_type st_reg;
  sync_glide_pkg::glide_state_type st_next;
  logic step;
  logic cal_start;
  logic watch_wr;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Address hit test shared by read and write paths
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] target);
    addr_hit = (a == target);
  endfunction : addr_hit

  assign watch_wr = bus.wr && addr_hit(bus.addr, `SYNC_WATCH_ADDR);
  assign cal_start = watch_wr && bus.wdata[`GLIDE_CTL_BIT];
  assign step = (st_reg.div == STEP_LAST);

  // ----------------------------------------------------------------
  // Next state: registers, glide and calibration
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.div_reset = 1'b0;
    st_next.rdata = 8'h00;
    st_next.div = step ? '0 : st_reg.div + 1'b1;
    // Register writes, unused bits masked off
    if (watch_wr)
      st_next.watch_cfg = bus.wdata & `SYNC_WATCH_MASK;
    if (bus.wr && addr_hit(bus.addr, `IRQ_PIN_ADDR))
      st_next.irq_cfg = bus.wdata[`IRQ_CFG_MSB:0];
    // Register reads, unmapped addresses give zero
    if (bus.rd && addr_hit(bus.addr, `SYNC_WATCH_ADDR))
      st_next.rdata = st_reg.watch_cfg;
    else if (bus.rd && addr_hit(bus.addr, `IRQ_PIN_ADDR))
      st_next.rdata = {5'h00, st_reg.irq_cfg};
    // Offset glide and calibration sequencer
    unique case (st_reg.cal)
      sync_glide_pkg::CAL_IDLE:
      begin
        if (cal_start)
        begin
          st_next.cal = sync_glide_pkg::CAL_HOLD;
          st_next.holdover = 1'b1;
        end
        else if (!st_reg.watch_cfg[`GLIDE_CTL_BIT] && step)
        begin
          if (st_reg.offset < phase_target)
            st_next.offset = st_reg.offset + 1'b1;
          else if (st_reg.offset > phase_target)
            st_next.offset = st_reg.offset - 1'b1;
        end
      end
      sync_glide_pkg::CAL_HOLD:
        st_next.cal = sync_glide_pkg::CAL_DOWN;
      sync_glide_pkg::CAL_DOWN:
      begin
        if (st_reg.offset == '0)
        begin
          st_next.cal = sync_glide_pkg::CAL_DIVRST;
          st_next.div_reset = 1'b1;
        end
        else if (step)
          st_next.offset = st_reg.offset - 1'b1;
      end
      sync_glide_pkg::CAL_DIVRST:
        st_next.cal = sync_glide_pkg::CAL_UP;
      sync_glide_pkg::CAL_UP:
      begin
        if (st_reg.offset == phase_target)
          st_next.cal = sync_glide_pkg::CAL_EXIT;
        else if (step && st_reg.offset < phase_target)
          st_next.offset = st_reg.offset + 1'b1;
        else if (step)
          st_next.offset = st_reg.offset - 1'b1;
      end
      sync_glide_pkg::CAL_EXIT:
      begin
        st_next.holdover = 1'b0;
        st_next.cal = sync_glide_pkg::CAL_IDLE;
      end
      default:
      begin
        st_next.cal = sync_glide_pkg::CAL_IDLE;
        st_next.holdover = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= RESET_STATE;
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Sync edge watchdog
  // ----------------------------------------------------------------
  sync_edge_watch #(
    .WINDOW_BASE(WINDOW_BASE)
  ) u_watch (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sync_in(sync_in),
    .in_clk(in_clk),
    .limit(st_reg.watch_cfg[`LIMIT_MSB:`LIMIT_LSB]),
    .sync_alarm(sync_alarm)
  );

  // Outputs from registers
  assign rd_data = st_reg.rdata;
  assign phase_offset = st_reg.offset;
  assign holdover_req = st_reg.holdover;
  assign divider_reset = st_reg.div_reset;
  assign irq_pin_cfg = st_reg.irq_cfg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence divrst_seq;
    st_reg.cal == sync_glide_pkg::CAL_DOWN && st_reg.offset == '0
    ##1 divider_reset && holdover_req;
  endsequence

  glide_step_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_reg.cal == sync_glide_pkg::CAL_IDLE && !cal_start && step &&
     !st_reg.watch_cfg[`GLIDE_CTL_BIT] && st_reg.offset < phase_target)
    |=> phase_offset == $past(phase_offset) + 1'b1)
    else $error("offset did not glide up");

  cal_start_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_reg.cal == sync_glide_pkg::CAL_IDLE && cal_start)
    |=> st_reg.cal == sync_glide_pkg::CAL_HOLD && holdover_req)
    else $error("calibration did not start");

  div_reset_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    divrst_seq |=> st_reg.cal == sync_glide_pkg::CAL_UP
    && !divider_reset)
    else $error("divider reset sequence broken");

  holdover_span_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_reg.cal != sync_glide_pkg::CAL_IDLE) |-> holdover_req)
    else $error("holdover dropped during calibration");

  limit_field_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    watch_wr |=> st_reg.watch_cfg[`LIMIT_MSB:`LIMIT_LSB] ==
    $past(bus.wdata[`LIMIT_MSB:`LIMIT_LSB]))
    else $error("limit field not written");

  unused_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (bus.rd && addr_hit(bus.addr, `IRQ_PIN_ADDR))
    |=> rd_data[7:3] == 5'h00 && rd_data[2:0] == $past(st_reg.irq_cfg))
    else $error("unused bits not zero");

endmodule : sync_monitor_phase_ramp

// file: sync_glide_cfg.svh
// Offsets, field positions, reset values and timing counts of the
// sync monitor and phase glide block.
// Assumes a 50 MHz system clock and an 8-bit register port.
`ifndef SYNC_GLIDE_CFG_SVH
`define SYNC_GLIDE_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SYNC_WATCH_ADDR 8'h7c
`define IRQ_PIN_ADDR 8'h7d
`define SYNC_WATCH_RESET 8'h2b
`define IRQ_PIN_RESET 8'h02
`define SYNC_WATCH_MASK 8'hf0
`define IRQ_PIN_MASK 8'h07

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GLIDE_CTL_BIT 7
`define LIMIT_MSB 6
`define LIMIT_LSB 4
`define IRQ_CFG_MSB 2

// ----------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------
`define PHASE_W 16
`define WATCH_CNT_W 16
`define CLK_PERIOD_NS 20
`define GLIDE_STEP_NS 1000
`define GLIDE_STEP_CYC ((`GLIDE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GLIDE_DIV_W 6

`endif

// file: sync_glide_pkg.sv
// Types shared by the sync monitor and phase glide block.
// Assumes sync_glide_cfg.svh supplies widths.
`include "sync_glide_cfg.svh"

package sync_glide_pkg;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // ----------------------------------------------------------------
  // Calibration sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    CAL_IDLE = 6'b00_0001,
    CAL_HOLD = 6'b00_0010,
    CAL_DOWN = 6'b00_0100,
    CAL_DIVRST = 6'b00_1000,
    CAL_UP = 6'b01_0000,
    CAL_EXIT = 6'b10_0000
  } cal_state_type;

  // ----------------------------------------------------------------
  // Module state records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] watch_cfg;
    logic [2:0] irq_cfg;
    logic [7:0] rdata;
    cal_state_type cal;
    logic [`PHASE_W-1:0] offset;
    logic [`GLIDE_DIV_W-1:0] div;
    logic holdover;
    logic div_reset;
  } glide_state_type;

  typedef struct packed {
    logic sync_s1;
    logic sync_s2;
    logic sync_s3;
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic [`WATCH_CNT_W-1:0] count;
    logic alarm;
  } watch_state_type;

endpackage : sync_glide_pkg

// file: sync_edge_watch.sv
// Frame-sync edge watchdog counting input clock cycles.
// Assumes sync and input clock are asynchronous pins.
`timescale 1ns/100ps
`include "sync_glide_cfg.svh"

module sync_edge_watch #(
  parameter logic [`WATCH_CNT_W-1:0] WINDOW_BASE = 16'h0001
) (
  input wire logic clk_sys, // System clock
  input wire logic arst_n, // Async reset, low
  input wire logic sync_in, // Selected frame-sync pin
  input wire logic in_clk, // Input reference clock pin
  input wire logic [2:0] limit, // Window code
  output logic sync_alarm // Alarm level
);

  sync_glide_pkg::watch_state_type st_reg;
  sync_glide_pkg::watch_state_type st_next;
  logic sync_edge;
  logic clk_edge;
  logic [`WATCH_CNT_W-1:0] window;

  // ----------------------------------------------------------------
  // Edge detection and window counter
  // ----------------------------------------------------------------
  // Window length doubles with each code step
  assign window = WINDOW_BASE << limit;
  assign sync_edge = st_reg.sync_s2 & ~st_reg.sync_s3;
  assign clk_edge = st_reg.clk_s2 & ~st_reg.clk_s3;

  // Next state
  always_comb
  begin
    st_next = st_reg;
    st_next.sync_s1 = sync_in;
    st_next.sync_s2 = st_reg.sync_s1;
    st_next.sync_s3 = st_reg.sync_s2;
    st_next.clk_s1 = in_clk;
    st_next.clk_s2 = st_reg.clk_s1;
    st_next.clk_s3 = st_reg.clk_s2;
    if (sync_edge)
    begin
      st_next.count = '0;
      st_next.alarm = 1'b0;
    end
    else if (st_reg.count >= window)
    begin
      st_next.alarm = 1'b1;
    end
    else if (clk_edge)
    begin
      st_next.count = st_reg.count + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign sync_alarm = st_reg.alarm;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sync_clears_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sync_edge |=> !sync_alarm && st_reg.count == '0)
    else $error("sync edge did not clear alarm");

  window_alarm_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!sync_edge && st_reg.count >= window) |=> sync_alarm)
    else $error("alarm missing after window");

endmodule : sync_edge_watch

// file: tb_top.sv
// Self-checking bench for the sync monitor and phase glide block.
// Assumes the package and the config header are compiled first.
`timescale 1ns/100ps
`include "sync_glide_cfg.svh"

module tb_top;
  logic clk_sys;
  logic arst_n;
  sync_glide_pkg::reg_req_type bus;
  logic [7:0] rd_data;
  logic [`PHASE_W-1:0] phase_target;
  logic sync_in;
  logic in_clk;
  logic [`PHASE_W-1:0] phase_offset;
  logic holdover_req;
  logic divider_reset;
  logic sync_alarm;
  logic [2:0] irq_pin_cfg;
  int n_mismatch;
  int n_tests;
  int seed;
  int i;
  logic [7:0] cfg_m;
  logic [7:0] irq_m;
  logic [`PHASE_W-1:0] tgt;

  // ----------------------------------------------------------------
  // Block under test
  // ----------------------------------------------------------------
  sync_monitor_phase_ramp #(.WINDOW_BASE(16'h0001))
    sync_monitor_phase_ramp_inst (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .bus(bus),
    .rd_data(rd_data),
    .phase_target(phase_target),
    .sync_in(sync_in),
    .in_clk(in_clk),
    .phase_offset(phase_offset),
    .holdover_req(holdover_req),
    .divider_reset(divider_reset),
    .sync_alarm(sync_alarm),
    .irq_pin_cfg(irq_pin_cfg)
  );

  // 50 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Compare, bus and stimulus tasks
  // ----------------------------------------------------------------
  task chk_reg(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_reg

  task chk_out(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_out

  task settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle

  // Write also updates the model copy with unused bits dropped
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    if (a == `SYNC_WATCH_ADDR) cfg_m = d & `SYNC_WATCH_MASK;
    if (a == `IRQ_PIN_ADDR) irq_m = d & `IRQ_PIN_MASK;
    #1;
  endtask : wr_reg

  // Read data is taken in the one cycle after the strobe
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1;
    chk_reg(rd_data, e);
  endtask : rd_chk

  task in_edges(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk_sys);
      in_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      in_clk <= 1'b0;
    end
  endtask : in_edges

  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    arst_n = 1'b0;
    bus = '0;
    phase_target = '0;
    sync_in = 1'b0;
    in_clk = 1'b0;
    seed = 19;
    n_mismatch = 0;
    n_tests = 0;
    cfg_m = `SYNC_WATCH_RESET & `SYNC_WATCH_MASK;
    irq_m = `IRQ_PIN_RESET;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd_chk(`SYNC_WATCH_ADDR, cfg_m);
    rd_chk(`IRQ_PIN_ADDR, irq_m);
    chk_out(16'(irq_pin_cfg), 16'(irq_m));
    $display("reset test done");
    // Random writes, unmapped place, read data gone next cycle
    for (i = 0; i < 16; i++)
    begin
      wr_reg(`SYNC_WATCH_ADDR, 8'($random(seed)) & 8'h7f);
      wr_reg(`IRQ_PIN_ADDR, 8'($random(seed)));
      wr_reg(8'h7e, 8'($random(seed)));
      rd_chk(`SYNC_WATCH_ADDR, cfg_m);
      rd_chk(`IRQ_PIN_ADDR, irq_m);
      rd_chk(8'h7e, 8'h00);
      settle(1);
      chk_reg(rd_data, 8'h00);
      chk_out(16'(irq_pin_cfg), 16'(irq_m));
    end
    $display("register test done");
    // Glide up, then one step down
    wr_reg(`SYNC_WATCH_ADDR, 8'h00);
    tgt = 16'(2 + ($random(seed) & 3));
    @(posedge clk_sys);
    phase_target <= tgt;
    settle(tgt * `GLIDE_STEP_CYC + 60);
    chk_out(phase_offset, tgt);
    tgt = tgt - 16'h0001;
    @(posedge clk_sys);
    phase_target <= tgt;
    settle(`GLIDE_STEP_CYC + 60);
    chk_out(phase_offset, tgt);
    $display("glide test done");
    // Calibration through holdover
    wr_reg(`SYNC_WATCH_ADDR, 8'h80);
    chk_out(16'(holdover_req), 16'h0001);
    for (i = 0; i < 1000 && divider_reset !== 1'b1; i++) settle(1);
    chk_out(16'(divider_reset), 16'h0001);
    chk_out(phase_offset, 16'h0000);
    chk_out(16'(holdover_req), 16'h0001);
    settle(1);
    chk_out(16'(divider_reset), 16'h0000);
    for (i = 0; i < 1000 && holdover_req !== 1'b0; i++) settle(1);
    chk_out(16'(holdover_req), 16'h0000);
    chk_out(phase_offset, tgt);
    rd_chk(`SYNC_WATCH_ADDR, cfg_m);
    // Offset not followed while the control bit stays set
    @(posedge clk_sys);
    phase_target <= tgt + 16'h0003;
    settle(200);
    chk_out(phase_offset, tgt);
    $display("calibration test done");
    // Each window code: one edge short stays quiet, next edge alarms
    for (i = 0; i < 8; i++)
    begin
      wr_reg(`SYNC_WATCH_ADDR, 8'(i << 4));
      @(posedge clk_sys);
      sync_in <= 1'b1;
      repeat (6) @(posedge clk_sys);
      sync_in <= 1'b0;
      settle(8);
      in_edges((1 << i) - 1);
      settle(8);
      chk_out(16'(sync_alarm), 16'h0000);
      in_edges(1);
      settle(8);
      chk_out(16'(sync_alarm), 16'h0001);
    end
    // Control bit cleared again: glide resumes toward the raised target
    chk_out(phase_offset, tgt + 16'h0003);
    $display("sync window test done");
    stop_test();
  end

  // Cuts a hang short
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    $display("watchdog expired");
    stop_test();
  end
endmodule : tb_top
